// file: fpm_defs.vh
// Behaviour
// - flash reads answer over cpu addresses 4000 to ffff as three 16 kb pages
// - middle window 8000 to bfff maps onto the page named by page select
// - page select 3e or 3f shows a fixed low or high page twice
// - page select 30 to 3f: four values per block, blocks 3,2,1,0, quarters in order
// - a block whose protection open bit shows protection is wholly protected
// - each block has independently enabled lower and higher protected areas
// - low area 8000 up to 81ff/83ff/87ff/8fff; high area f800/f000/e000/c000 to ffff
// - control and status registers decode at base plus 100 through base plus 10f
// - the 16 byte protection and security field sits in flash block 0
// - ff00-ff07 keys, ff0a-ff0d block 3..0 protection bytes, ff0f option byte
// - bytes base plus 104 to 10b exist per block, chosen by bank select bits
`ifndef FPM_DEFS_VH
`define FPM_DEFS_VH
// cpu window edges
`define FPM_CPU_LO        16'h4000
`define FPM_MID_LO        16'h8000
`define FPM_MID_HI        16'hbfff
`define FPM_TOP_LO        16'hc000
// page select values
`define FPM_PAGE_BASE     8'h30
`define FPM_PAGE_FIX_LO   8'h3e
`define FPM_PAGE_FIX_HI   8'h3f
// block relative protected area edges
`define FPM_LOW_AREA_LO   16'h8000
`define FPM_LOW_UNIT      16'h0200
`define FPM_HIGH_AREA_HI  16'hffff
`define FPM_HIGH_UNIT     16'h0800
// register space offsets from base
`define FPM_REG_LO        16'h0100
`define FPM_REG_HI        16'h010f
`define FPM_BANK_LO       4'h4
`define FPM_BANK_HI       4'hb
// protection and security field in block 0, block relative
`define FPM_CFG_BASE      16'hff00
`define FPM_CFG_KEY_LAST  4'h7
`define FPM_CFG_PROT_B3   4'ha
`define FPM_CFG_PROT_B0   4'hd
`define FPM_CFG_OPT       4'hf
`endif

// file: fpm_prot_check.v
`timescale 1ns/1ps
`include "fpm_defs.vh"
module fpm_prot_check (
  input  wire [15:0] rel_addr,
  input  wire        prot_open,
  input  wire        low_en,
  input  wire [1:0]  low_size,
  input  wire        high_en,
  input  wire [1:0]  high_size,
  output wire        protected_hit
);
  wire [15:0] low_last;
  wire [15:0] high_first;
  wire        in_low;
  wire        in_high;

  // low area grows upward from 8000, high area downward from ffff
  assign low_last   = `FPM_LOW_AREA_LO + (`FPM_LOW_UNIT << low_size) - 16'h0001;
  assign high_first = `FPM_HIGH_AREA_HI - (`FPM_HIGH_UNIT << high_size) + 16'h0001;
  assign in_low     = low_en && (rel_addr >= `FPM_LOW_AREA_LO) && (rel_addr <= low_last);
  assign in_high    = high_en && (rel_addr >= high_first);
  // a closed block overrides both areas
  assign protected_hit = !prot_open || in_low || in_high;
endmodule

// file: fpm_decode.v
`timescale 1ns/1ps
`include "fpm_defs.vh"
module fpm_decode #(
  parameter [15:0] REG_BASE = 16'h0000
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        access_valid,
  input  wire        access_prog,
  input  wire [15:0] cpu_addr,
  input  wire [7:0]  page_select_register,
  input  wire [3:0]  protection_open_bit,
  input  wire [3:0]  low_area_en,
  input  wire [7:0]  low_area_size,
  input  wire [3:0]  high_area_en,
  input  wire [7:0]  high_area_size,
  input  wire [1:0]  bank_select_bits,
  output reg         flash_hit_r,
  output reg  [1:0]  flash_block_r,
  output reg  [15:0] block_addr_r,
  output reg         protected_r,
  output reg         cfg_key_hit_r,
  output reg         cfg_prot_hit_r,
  output reg  [1:0]  cfg_prot_block_r,
  output reg         cfg_opt_hit_r,
  output reg         reg_hit_r,
  output reg  [3:0]  reg_offset_r,
  output reg         reg_banked_r,
  output reg  [1:0]  reg_bank_r
);
  reg  [7:0]  page_nxt;
  reg         hit_nxt;
  reg  [1:0]  block_nxt;
  reg  [15:0] rel_nxt;
  wire [3:0]  blk_prot;
  wire [15:0] reg_rel;
  wire        reg_in;
  wire [3:0]  reg_off;
  wire        cfg_in;
  wire [3:0]  cfg_off;
  // window and field decode
  wire        lo_win;
  wire        mid_win;
  wire        top_win;
  wire        key_in;
  wire        prot_byte_in;
  wire        opt_in;
  wire        bank_off;
  // next values of the output flops
  reg         flash_hit_nxt;
  reg  [1:0]  flash_block_nxt;
  reg  [15:0] block_addr_nxt;
  reg         protected_nxt;
  reg         cfg_key_hit_nxt;
  reg         cfg_prot_hit_nxt;
  reg  [1:0]  cfg_prot_block_nxt;
  reg         cfg_opt_hit_nxt;
  reg         reg_hit_nxt;
  reg  [3:0]  reg_offset_nxt;
  reg         reg_banked_nxt;
  reg  [1:0]  reg_bank_nxt;

  // the three 16 kb cpu windows; anything below 4000 belongs to other
  // memories and never reaches the page logic
  assign lo_win  = (cpu_addr >= `FPM_CPU_LO) && (cpu_addr < `FPM_MID_LO);
  assign mid_win = (cpu_addr >= `FPM_MID_LO) && (cpu_addr <= `FPM_MID_HI);
  assign top_win = (cpu_addr >= `FPM_TOP_LO);

  // page choice: the fixed windows behave as pages 3e and 3f, so a middle
  // window set to either simply aliases them
  always @*
  begin
    page_nxt  = page_select_register;
    hit_nxt   = 1'b0;
    block_nxt = 2'b00;
    rel_nxt   = 16'h0000;
    if (lo_win || mid_win || top_win)
    begin
      if (lo_win)
        page_nxt = `FPM_PAGE_FIX_LO;
      else if (top_win)
        page_nxt = `FPM_PAGE_FIX_HI;
      else
        page_nxt = page_select_register;
      // only 30..3f reach flash; other pages belong to other memories
      if ((page_nxt & 8'hf0) == `FPM_PAGE_BASE)
      begin
        hit_nxt   = 1'b1;
        block_nxt = ~page_nxt[3:2];
        rel_nxt   = {page_nxt[1:0], cpu_addr[13:0]};
      end
    end
  end

  // one checker per block, result picked by the decoded block; four
  // comparators cost area but keep the block select out of the compare
  // path, so the verdict settles as early as the address does
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_blk
      fpm_prot_check u_chk (
        .rel_addr      (rel_nxt),
        .prot_open     (protection_open_bit[gi]),
        .low_en        (low_area_en[gi]),
        .low_size      (low_area_size[2*gi+1:2*gi]),
        .high_en       (high_area_en[gi]),
        .high_size     (high_area_size[2*gi+1:2*gi]),
        .protected_hit (blk_prot[gi])
      );
    end
  endgenerate

  // register space decode; wrap below base falls outside the window.
  // a base that overlaps flash lets both hits rise, the caller arbitrates
  assign reg_rel = cpu_addr - REG_BASE;
  assign reg_in  = (cpu_addr >= REG_BASE) && (reg_rel >= `FPM_REG_LO)
                   && (reg_rel <= `FPM_REG_HI);
  assign reg_off = reg_rel[3:0];

  // protection and security field lives only in block 0
  assign cfg_in  = hit_nxt && (block_nxt == 2'b00)
                   && ((rel_nxt & 16'hfff0) == `FPM_CFG_BASE);
  assign cfg_off = rel_nxt[3:0];

  // the reserved bytes ff08, ff09 and ff0e match none of these, so
  // a stray access there raises no field flag at all
  assign key_in       = cfg_in && (cfg_off <= `FPM_CFG_KEY_LAST);
  assign prot_byte_in = cfg_in && (cfg_off >= `FPM_CFG_PROT_B3)
                        && (cfg_off <= `FPM_CFG_PROT_B0);
  assign opt_in       = cfg_in && (cfg_off == `FPM_CFG_OPT);
  // banked bytes sit at offsets 4..b of the sixteen
  assign bank_off     = (reg_off >= `FPM_BANK_LO) && (reg_off <= `FPM_BANK_HI);

  // next values; strobe gating happens here so the flops below stay plain
  // and every output is valid one cycle after the request
  always @*
  begin
    flash_hit_nxt      = access_valid && hit_nxt;
    flash_block_nxt    = block_nxt;
    block_addr_nxt     = rel_nxt;
    // reads never flag; only program or erase targets are judged
    protected_nxt      = access_valid && access_prog && hit_nxt
                         && blk_prot[block_nxt];
    cfg_key_hit_nxt    = access_valid && key_in;
    cfg_prot_hit_nxt   = access_valid && prot_byte_in;
    // ff0a is block 3 down to ff0d block 0; meaningless outside that span
    cfg_prot_block_nxt = 2'b11 - (cfg_off[1:0] - 2'b10);
    cfg_opt_hit_nxt    = access_valid && opt_in;
    reg_hit_nxt        = access_valid && reg_in;
    reg_offset_nxt     = reg_off;
    reg_banked_nxt     = access_valid && reg_in && bank_off;
    // unbanked bytes report copy 0
    reg_bank_nxt       = bank_off ? bank_select_bits : 2'b00;
  end

  // flash position; block and address run free, only the hit flag says
  // whether the decode belongs to a real request
  always @(posedge clock)
  begin
    if (reset)
    begin
      flash_hit_r   <= 1'b0;
      flash_block_r <= 2'b00;
      block_addr_r  <= 16'h0000;
    end
    else
    begin
      flash_hit_r   <= flash_hit_nxt;
      flash_block_r <= flash_block_nxt;
      block_addr_r  <= block_addr_nxt;
    end
  end

  // protection verdict for the command logic; held low in reset so no
  // command can be refused before the first real request
  always @(posedge clock)
  begin
    if (reset)
    begin
      protected_r <= 1'b0;
    end
    else
    begin
      protected_r <= protected_nxt;
    end
  end

  // protection and security field hits; the block number is only
  // meaningful while the protection byte flag is high
  always @(posedge clock)
  begin
    if (reset)
    begin
      cfg_key_hit_r    <= 1'b0;
      cfg_prot_hit_r   <= 1'b0;
      cfg_prot_block_r <= 2'b00;
      cfg_opt_hit_r    <= 1'b0;
    end
    else
    begin
      cfg_key_hit_r    <= cfg_key_hit_nxt;
      cfg_prot_hit_r   <= cfg_prot_hit_nxt;
      cfg_prot_block_r <= cfg_prot_block_nxt;
      cfg_opt_hit_r    <= cfg_opt_hit_nxt;
    end
  end

  // register space hits; offset and bank run free like the flash address,
  // so a consumer must qualify them with the hit flags
  always @(posedge clock)
  begin
    if (reset)
    begin
      reg_hit_r    <= 1'b0;
      reg_offset_r <= 4'h0;
      reg_banked_r <= 1'b0;
      reg_bank_r   <= 2'b00;
    end
    else
    begin
      reg_hit_r    <= reg_hit_nxt;
      reg_offset_r <= reg_offset_nxt;
      reg_banked_r <= reg_banked_nxt;
      reg_bank_r   <= reg_bank_nxt;
    end
  end
endmodule

// file: fpm_decode_asserts.sv
`timescale 1ns/1ps
module fpm_chk (
  input logic        clock,
  input logic        reset,
  input logic        access_valid,
  input logic        access_prog,
  input logic [15:0] cpu_addr,
  input logic [7:0]  page_select_register,
  input logic [3:0]  protection_open_bit,
  input logic        flash_hit_r,
  input logic [1:0]  flash_block_r,
  input logic [15:0] block_addr_r,
  input logic        protected_r,
  input logic        cfg_key_hit_r,
  input logic        reg_hit_r,
  input logic [3:0]  reg_offset_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // short names for the request qualifiers
  logic       v;
  logic [1:0] q;
  logic [7:0] pg;
  assign v = access_valid;
  assign q = cpu_addr[15:14];
  assign pg = page_select_register;
  property p_below; v && q == 2'b00 && cpu_addr[15:12] != 4'h0 |=> !flash_hit_r; endproperty
  a_below: assert property (p_below) else $error("flash hit below window");
  property p_top; v && q == 2'b11 |=> flash_hit_r && flash_block_r == 2'd0; endproperty
  a_top: assert property (p_top) else $error("top window not block zero");
  property p_mid; v && q == 2'b10 && pg[7:4] == 4'h3 |=> flash_block_r == 2'd3 - $past(pg[3:2])
    && block_addr_r == {$past(pg[1:0]), $past(cpu_addr[13:0])}; endproperty
  a_mid: assert property (p_mid) else $error("middle window mapped wrong");
  property p_off; v && q == 2'b10 && pg[7:4] != 4'h3 |=> !flash_hit_r; endproperty
  a_off: assert property (p_off) else $error("hit on non flash page");
  property p_fix; v && q == 2'b01 |=> flash_block_r == 2'd0 && block_addr_r[15:14] == 2'b10;
  endproperty
  a_fix: assert property (p_fix) else $error("low fixed page wrong");
  property p_closed; v && access_prog && q == 2'b11 && !protection_open_bit[0] |=> protected_r;
  endproperty
  a_closed: assert property (p_closed) else $error("closed block not protected");
  property p_read; !(v && access_prog) |=> !protected_r; endproperty
  a_read: assert property (p_read) else $error("protected without program");
  property p_key; v && cpu_addr[15:3] == 13'h1fe0 |=> cfg_key_hit_r; endproperty
  a_key: assert property (p_key) else $error("key bytes missed");
  property p_reg; v && cpu_addr[15:4] == 12'h010 |=> reg_hit_r
    && reg_offset_r == $past(cpu_addr[3:0]); endproperty
  a_reg: assert property (p_reg) else $error("register space missed");
endmodule
bind fpm_decode fpm_chk u_chk (.*);

// file: fpm_host.sv
`timescale 1ns/1ps
module fpm_host (
  input  logic        clock,
  output logic        access_valid,
  output logic        access_prog,
  output logic [15:0] cpu_addr,
  output logic [7:0]  page_select_register
);
  initial
  begin
    access_valid = 1'b0;
    access_prog = 1'b0;
    cpu_addr = 16'h0000;
    page_select_register = 8'h00;
  end
  // one access per call; the page is set before the window is used
  task req(input logic p, input logic [7:0] pgv, input logic [15:0] a);
    @(negedge clock);
    page_select_register = pgv;
    access_prog = p;
    cpu_addr = a;
    access_valid = 1'b1;
    @(negedge clock);
    access_valid = 1'b0;
    cpu_addr = ~a; // idle bus carries junk, so stale addresses cannot pass
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic reset, access_valid, access_prog, flash_hit_r, protected_r, cfg_key_hit_r;
  logic cfg_prot_hit_r, cfg_opt_hit_r, reg_hit_r, reg_banked_r;
  logic [1:0] bank_select_bits, flash_block_r, cfg_prot_block_r, reg_bank_r;
  logic [3:0] protection_open_bit, low_area_en, high_area_en, reg_offset_r;
  logic [7:0] page_select_register, low_area_size, high_area_size;
  logic [15:0] cpu_addr, block_addr_r, lim;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  fpm_host host (.*);
  fpm_decode dut (.*);
  task chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // every paged value through the middle window, then one off the flash, an alias of page 3f and one address below 4000
  task t_pages;
    for (int p = 0; p < 16; p++)
    begin
      host.req(1'b0, 8'h30 + 8'(p), 16'h9abc);
      chk("block", 16'(3 - p / 4), {14'h0, flash_block_r});
      chk("addr", {p[1:0], 14'h1abc}, block_addr_r);
      chk("hit", 16'h1, {15'h0, flash_hit_r});
    end
    host.req(1'b0, 8'h2f, 16'h8000);
    chk("off", 16'h0, {15'h0, flash_hit_r});
    host.req(1'b0, 8'h3f, 16'h8010);
    chk("dup", 16'hc010, block_addr_r);
    host.req(1'b0, 8'h31, 16'h3fff);
    chk("low", 16'h0, {15'h0, flash_hit_r});
  endtask
  // area edges for each size, then a closed block
  task t_prot;
    for (int s = 0; s < 4; s++)
    begin
      {low_area_en, high_area_en, low_area_size, high_area_size} = {8'h10, 8'(s), 8'(s)};
      lim = 16'h4000 + (16'h0200 << s);
      host.req(1'b1, 8'h31, lim - 16'h1);
      chk("lo_in", 16'h1, {15'h0, protected_r});
      host.req(1'b1, 8'h31, lim);
      chk("lo_out", 16'h0, {15'h0, protected_r});
      low_area_en = 4'h0;
      high_area_en = 4'h1;
      lim = 16'h0 - (16'h0800 << s);
      host.req(1'b1, 8'h30, lim);
      chk("hi_in", 16'h1, {15'h0, protected_r});
      host.req(1'b1, 8'h30, lim - 16'h1);
      chk("hi_out", 16'h0, {15'h0, protected_r});
    end
    {high_area_en, protection_open_bit} = 8'h0e;
    host.req(1'b1, 8'h3c, 16'h8000);
    chk("closed", 16'h1, {15'h0, protected_r});
    host.req(1'b1, 8'h3c, 16'hfe00);
    chk("closed_top", 16'h1, {15'h0, protected_r});
    host.req(1'b0, 8'h3c, 16'h8000);
    chk("read", 16'h0, {15'h0, protected_r});
    host.req(1'b1, 8'h38, 16'h8000);
    chk("open", 16'h0, {15'h0, protected_r});
  endtask
  // protection field bytes and every register offset
  task t_cfg_reg;
    for (int i = 0; i < 16; i++)
    begin
      host.req(1'b0, 8'h30, 16'hff00 + 16'(i));
      chk("key", 16'(i < 8), {15'h0, cfg_key_hit_r});
      chk("prot", 16'(i > 9 && i < 14), {15'h0, cfg_prot_hit_r});
      if (i > 9 && i < 14)
        chk("pblk", 16'(13 - i), {14'h0, cfg_prot_block_r});
      chk("opt", 16'(i == 15), {15'h0, cfg_opt_hit_r});
      bank_select_bits = 2'(i);
      host.req(1'b0, 8'h30, 16'h0100 + 16'(i));
      chk("reg", 16'h1, {15'h0, reg_hit_r});
      chk("roff", 16'(i), {12'h0, reg_offset_r});
      chk("banked", 16'(i > 3 && i < 12), {15'h0, reg_banked_r});
      chk("bank", (i > 3 && i < 12) ? 16'(i % 4) : 16'h0, {14'h0, reg_bank_r});
    end
  endtask
  initial
  begin
    forever #2 clock = ~clock;
  end
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  initial
  begin
    {reset, protection_open_bit, low_area_en, high_area_en} = {1'b1, 12'hf00};
    {low_area_size, high_area_size, bank_select_bits} = 18'h0;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    t_pages;
    t_prot;
    protection_open_bit = 4'hf;
    t_cfg_reg;
    give_verdict;
  end
endmodule
